// ---- clock_output_control_pkg.sv ----
// constants and register map of the clock output control register bank
// Operation
// - byte 1D bits 7,6 make differential outputs obey the second enable pin when its function is 01
// - byte 1D bits 5,4 enable the differential outputs, reset set
// - byte 1D bit 3 picks fourth divider source: second PLL or crystal
// - each single-ended output has a slew bit, 1 strong, reset 0
// - each supply domain has a two-bit level code, 11 is 1.8 V
// - byte 1E bits 6:5 set the first enable pin's function
// - byte 1E bits 3:2 set the third enable pin's function, 01 undefined
// - byte 1E bits 1:0 select frequency setting; byte 20 bit 4 enables dynamic mode
// - single-ended output enables at 1E bits 7,4 and 20 bit 7, reset set
// - second single-ended source select: fifth divider at 0, fourth at 1
// - byte 1F bit 3 loop order, bit 1 third pole enable
// - byte 1F bit 2 enables second PLL channel two, reset set
// - byte 20 bits 6:5 set the second enable pin's function
// - byte 20 bit 3 enables watchdog, bits 2:1 select its period
// - byte 20 bit 0 is a read-only sticky alarm flag, reset 0
// - byte 21 bit 6 picks third single-ended source when free-run bit clear
// - byte 21 bit 2 tri-states differential outputs at power down
// - byte 21 bits 1,0 set B-leg polarity of the differential outputs
// - byte 22 bit 7 picks first differential source, reset 1
// - byte 22 bits 5:4 set first differential type, reset 11
// - byte 22 bit 1 CMOS slew and bit 0 B-leg enable of first differential
package clock_output_control_pkg;

    // ************************************************************
    // register offsets and reset values
    // ************************************************************
    localparam logic [7:0] OFS_GATING_ENABLES  = 8'h1D;
    localparam logic [7:0] OFS_PIN_FUNC_FREQ   = 8'h1E;
    localparam logic [7:0] OFS_SOURCE_SUPPLY   = 8'h1F;
    localparam logic [7:0] OFS_WATCHDOG_PIN_B  = 8'h20;
    localparam logic [7:0] OFS_THIRD_DIFF_OPTS = 8'h21;
    localparam logic [7:0] OFS_FIRST_DIFF_CFG  = 8'h22;

    localparam logic [7:0] RST_GATING_ENABLES  = 8'h30;
    localparam logic [7:0] RST_PIN_FUNC_FREQ   = 8'h90;
    localparam logic [7:0] RST_SOURCE_SUPPLY   = 8'h84;
    localparam logic [7:0] RST_WATCHDOG_PIN_B  = 8'h80;
    localparam logic [7:0] RST_THIRD_DIFF_OPTS = 8'h00;
    localparam logic [7:0] RST_FIRST_DIFF_CFG  = 8'hB4;

    // writable bits of the first differential byte; others are reserved
    localparam logic [7:0] MASK_FIRST_DIFF_CFG = 8'hB3;
    // writable bits of the watchdog byte; bit 0 is the alarm
    localparam logic [7:0] MASK_WATCHDOG_PIN_B = 8'hFE;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int POS_WD_ALARM  = 0;
    localparam int POS_WD_ENABLE = 3;
    localparam int POS_DYNAMIC_FREQ_ENABLE    = 4;

    // ************************************************************
    // enable pin function codes
    // ************************************************************
    localparam logic [1:0] PIN_FN_OUT_ENABLE = 2'h0;
    localparam logic [1:0] PIN_FN_ALT_ONE    = 2'h1;
    localparam logic [1:0] PIN_FN_SAVING     = 2'h2;
    localparam logic [1:0] PIN_FN_ALT_THREE  = 2'h3;

    // ************************************************************
    // watchdog periods
    // ************************************************************
    localparam int CLK_MHZ       = 100;
    localparam int WD_PERIOD0_MS = 250;
    localparam int WD_PERIOD1_MS = 500;
    localparam int WD_PERIOD2_MS = 2000;
    localparam int WD_PERIOD3_MS = 4000;
    localparam int WD_PERIOD0_CYC = WD_PERIOD0_MS * 1000 * CLK_MHZ;
    localparam int WD_PERIOD1_CYC = WD_PERIOD1_MS * 1000 * CLK_MHZ;
    localparam int WD_PERIOD2_CYC = WD_PERIOD2_MS * 1000 * CLK_MHZ;
    localparam int WD_PERIOD3_CYC = WD_PERIOD3_MS * 1000 * CLK_MHZ;

endpackage

// ---- clock_output_control_regs.sv ----
// register bank for output enables, pin functions, sources and watchdog
`timescale 1ns/100ps
module clock_output_control_regs #(
    parameter int WD_PERIOD0 = clock_output_control_pkg::WD_PERIOD0_CYC,
    parameter int WD_PERIOD1 = clock_output_control_pkg::WD_PERIOD1_CYC,
    parameter int WD_PERIOD2 = clock_output_control_pkg::WD_PERIOD2_CYC,
    parameter int WD_PERIOD3 = clock_output_control_pkg::WD_PERIOD3_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    input  wire logic       pin_a,
    input  wire logic       pin_b,
    input  wire logic       pin_c,
    output logic            diff_a_active,
    output logic            diff_b_active,
    output logic            single_a_active,
    output logic            single_b_active,
    output logic            single_c_active,
    output logic            single_a_saving,
    output logic            single_b_saving,
    output logic            single_c_saving,
    output logic            power_down_n,
    output logic            pin_reset,
    output logic      [1:0] dynamic_freq_control,
    output logic            fourth_divider_source,
    output logic      [2:0] single_slew,
    output logic      [5:0] supply_levels,
    output logic            single_b_source,
    output logic            single_c_source,
    output logic            single_c_slow_freerun,
    output logic            loop_order_select,
    output logic            loop_channel_two_enable,
    output logic            loop_third_pole_enable,
    output logic            diff_hiz_at_powerdown,
    output logic            diff_a_bleg_polarity,
    output logic            diff_b_bleg_polarity,
    output logic            diff_a_source,
    output logic      [1:0] diff_a_type,
    output logic            diff_a_cmos_slew,
    output logic            diff_a_bleg_enable,
    output logic            watchdog_alarm
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0] output_gating_and_enables;
    logic [7:0] pin_function_freq_select;
    logic [7:0] source_supply_loop_options;
    logic [7:0] watchdog_and_pin_two_function;
    logic [7:0] third_output_and_diff_options;
    logic [7:0] first_diff_output_config;
    logic       alarm;

    wire sel_1d = reg_addr == clock_output_control_pkg::OFS_GATING_ENABLES;
    wire sel_1e = reg_addr == clock_output_control_pkg::OFS_PIN_FUNC_FREQ;
    wire sel_1f = reg_addr == clock_output_control_pkg::OFS_SOURCE_SUPPLY;
    wire sel_20 = reg_addr == clock_output_control_pkg::OFS_WATCHDOG_PIN_B;
    wire sel_21 = reg_addr == clock_output_control_pkg::OFS_THIRD_DIFF_OPTS;
    wire sel_22 = reg_addr == clock_output_control_pkg::OFS_FIRST_DIFF_CFG;

    // only writable bits follow the host; reserved and alarm bits hold
    wire [7:0] next_20 = (reg_wdata & clock_output_control_pkg::MASK_WATCHDOG_PIN_B)
                       | (watchdog_and_pin_two_function & ~clock_output_control_pkg::MASK_WATCHDOG_PIN_B);
    wire [7:0] next_22 = (reg_wdata & clock_output_control_pkg::MASK_FIRST_DIFF_CFG)
                       | (clock_output_control_pkg::RST_FIRST_DIFF_CFG
                          & ~clock_output_control_pkg::MASK_FIRST_DIFF_CFG);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            output_gating_and_enables     <= clock_output_control_pkg::RST_GATING_ENABLES;
            pin_function_freq_select      <= clock_output_control_pkg::RST_PIN_FUNC_FREQ;
            source_supply_loop_options    <= clock_output_control_pkg::RST_SOURCE_SUPPLY;
            watchdog_and_pin_two_function <= clock_output_control_pkg::RST_WATCHDOG_PIN_B;
            third_output_and_diff_options <= clock_output_control_pkg::RST_THIRD_DIFF_OPTS;
            first_diff_output_config      <= clock_output_control_pkg::RST_FIRST_DIFF_CFG;
        end else if (reg_write) begin
            if (sel_1d) output_gating_and_enables <= reg_wdata;
            if (sel_1e) pin_function_freq_select <= reg_wdata;
            if (sel_1f) source_supply_loop_options <= reg_wdata;
            if (sel_20) watchdog_and_pin_two_function <= next_20;
            if (sel_21) third_output_and_diff_options <= reg_wdata;
            if (sel_22) first_diff_output_config <= next_22;
        end
    end

    // ************************************************************
    // watchdog
    // ************************************************************
    logic [31:0] wd_count;
    wire         wd_enable = watchdog_and_pin_two_function[clock_output_control_pkg::POS_WD_ENABLE];
    wire  [1:0]  wd_select = watchdog_and_pin_two_function[2:1];
    wire  [31:0] wd_limit  = (wd_select == 2'h0) ? WD_PERIOD0[31:0] :
                             (wd_select == 2'h1) ? WD_PERIOD1[31:0] :
                             (wd_select == 2'h2) ? WD_PERIOD2[31:0] : WD_PERIOD3[31:0];
    wire         wd_kick   = reg_write | reg_read;
    wire         wd_expire = wd_enable && !wd_kick && (wd_count >= wd_limit - 32'h0000_0001);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wd_count <= 32'h0000_0000;
            alarm    <= 1'b0;
        end else begin
            wd_count <= (!wd_enable || wd_kick || wd_expire) ? 32'h0000_0000 : wd_count + 32'h0000_0001;
            if (wd_expire) alarm <= 1'b1;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    wire [7:0] read_mux = sel_1d ? output_gating_and_enables :
                          sel_1e ? pin_function_freq_select :
                          sel_1f ? source_supply_loop_options :
                          sel_20 ? {watchdog_and_pin_two_function[7:1], alarm} :
                          sel_21 ? third_output_and_diff_options :
                          sel_22 ? first_diff_output_config : 8'h00;

    assign reg_hit = sel_1d | sel_1e | sel_1f | sel_20 | sel_21 | sel_22;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= read_mux;
        end
    end

    // ************************************************************
    // field decode
    // ************************************************************
    wire       diff_a_pin_gating = output_gating_and_enables[7];
    wire       diff_b_pin_gating = output_gating_and_enables[6];
    wire       diff_a_enable     = output_gating_and_enables[5];
    wire       diff_b_enable     = output_gating_and_enables[4];
    wire       single_a_enable   = pin_function_freq_select[7];
    wire       single_c_enable   = pin_function_freq_select[4];
    wire       single_b_enable   = watchdog_and_pin_two_function[7];
    wire [1:0] pin_a_function    = pin_function_freq_select[6:5];
    wire [1:0] pin_c_function    = pin_function_freq_select[3:2];
    wire [1:0] pin_b_function    = watchdog_and_pin_two_function[6:5];
    wire [1:0] freq_setting_select = pin_function_freq_select[1:0];
    wire       dynamic_freq_enable = watchdog_and_pin_two_function[clock_output_control_pkg::POS_DYNAMIC_FREQ_ENABLE];

    wire pin_b_joint = pin_b_function == clock_output_control_pkg::PIN_FN_ALT_ONE;
    wire pin_b_gate  = pin_b_joint ? pin_b : 1'b1;

    assign diff_a_active   = diff_a_enable && (!diff_a_pin_gating || pin_b_gate);
    assign diff_b_active   = diff_b_enable && (!diff_b_pin_gating || pin_b_gate);
    assign single_a_active = single_a_enable
                             && (pin_a_function != clock_output_control_pkg::PIN_FN_OUT_ENABLE || pin_a);
    assign single_b_active = single_b_enable
                             && (pin_b_function != clock_output_control_pkg::PIN_FN_OUT_ENABLE || pin_b);
    assign single_c_active = single_c_enable
                             && (pin_c_function != clock_output_control_pkg::PIN_FN_OUT_ENABLE || pin_c);
    assign single_a_saving = pin_a_function == clock_output_control_pkg::PIN_FN_SAVING && pin_a;
    assign single_b_saving = pin_b_function == clock_output_control_pkg::PIN_FN_SAVING && pin_b;
    assign single_c_saving = pin_c_function == clock_output_control_pkg::PIN_FN_SAVING && pin_c;
    assign power_down_n    = !(pin_a_function == clock_output_control_pkg::PIN_FN_ALT_ONE && !pin_a);
    assign pin_reset       = pin_b_function == clock_output_control_pkg::PIN_FN_ALT_THREE && pin_b;

    // pins override the stored setting only when configured as select bits
    wire freq_bit0 = (pin_a_function == clock_output_control_pkg::PIN_FN_ALT_THREE) ? pin_a
                                                                                    : freq_setting_select[0];
    wire freq_bit1 = (pin_c_function == clock_output_control_pkg::PIN_FN_ALT_THREE) ? pin_c
                                                                                    : freq_setting_select[1];
    assign dynamic_freq_control = dynamic_freq_enable ? {freq_bit1, freq_bit0} : 2'h0;

    assign fourth_divider_source   = output_gating_and_enables[3];
    assign single_slew             = {third_output_and_diff_options[3], source_supply_loop_options[4],
                                      output_gating_and_enables[2]};
    assign supply_levels           = {third_output_and_diff_options[5:4], source_supply_loop_options[6:5],
                                      output_gating_and_enables[1:0]};
    assign single_b_source         = source_supply_loop_options[7];
    assign loop_order_select       = source_supply_loop_options[3];
    assign loop_channel_two_enable = source_supply_loop_options[2];
    assign loop_third_pole_enable  = source_supply_loop_options[1];
    assign single_c_slow_freerun   = third_output_and_diff_options[7];
    assign single_c_source         = third_output_and_diff_options[6];
    assign diff_hiz_at_powerdown   = third_output_and_diff_options[2];
    assign diff_a_bleg_polarity    = third_output_and_diff_options[1];
    assign diff_b_bleg_polarity    = third_output_and_diff_options[0];
    assign diff_a_source           = first_diff_output_config[7];
    assign diff_a_type             = first_diff_output_config[5:4];
    assign diff_a_cmos_slew        = first_diff_output_config[1];
    assign diff_a_bleg_enable      = first_diff_output_config[0];
    assign watchdog_alarm          = alarm;

    // ************************************************************
    // assertions
    // ************************************************************
    a_alarm_sticky: assert property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(alarm) |-> ##1 alarm [*4]) else $error("alarm flag dropped");
    a_alarm_cause: assert property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(alarm) |-> $past(wd_enable)) else $error("alarm without watchdog");
    a_alarm_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
        reg_write && sel_20 && !alarm && !wd_expire |=> !alarm) else $error("write set alarm");
    a_reserved_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
        first_diff_output_config[6] == 1'b0 && first_diff_output_config[3:2] == 2'h1)
        else $error("reserved bits changed");
    a_diff_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
        diff_a_pin_gating && pin_b_joint && !pin_b |-> !diff_a_active) else $error("pin gating ignored");
    a_diff_enable: assert property (@(posedge clk) disable iff (!rst_sync_n)
        reg_write && sel_1d && !reg_wdata[4] |=> !diff_b_active) else $error("disable ignored");
    a_read_back: assert property (@(posedge clk) disable iff (!rst_sync_n)
        reg_write && sel_1d ##1 !reg_write ##1 reg_read && sel_1d && !reg_write
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("read back mismatch");
    a_freq_select: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !dynamic_freq_enable |-> dynamic_freq_control == 2'h0) else $error("frequency active while disabled");
    a_power_down: assert property (@(posedge clk) disable iff (!rst_sync_n)
        pin_a_function == clock_output_control_pkg::PIN_FN_ALT_ONE && !pin_a |-> !power_down_n)
        else $error("power down missed");
    a_reset_value: assert property (@(posedge clk) $rose(rst_sync_n) |-> diff_a_type == 2'h3
        && diff_a_source && loop_channel_two_enable) else $error("wrong reset value");

    c_alarm_raised: cover property (@(posedge clk) disable iff (!rst_sync_n) $rose(alarm));
    c_write_read: cover property (@(posedge clk) disable iff (!rst_sync_n) reg_write ##2 reg_read);
    c_pin_reset: cover property (@(posedge clk) disable iff (!rst_sync_n) pin_reset);
    c_dynamic_freq: cover property (@(posedge clk) disable iff (!rst_sync_n) dynamic_freq_control == 2'h3);

endmodule

// ---- reg_host_model.sv ----
// host model issuing whole-byte writes and reads on the register port
`timescale 1ns/100ps
module reg_host_model (
    input  wire logic       clk,
    output logic      [7:0] reg_addr  = 8'h00,
    output logic      [7:0] reg_wdata = 8'h00,
    output logic            reg_write = 1'b0,
    output logic            reg_read  = 1'b0,
    input  wire logic [7:0] reg_rdata
);
    // one strobe cycle per byte, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// ---- tb_top.sv ----
// self-checking testbench for the clock output control register bank
`timescale 1ns/100ps
module tb_top;
    logic       clk = 1'b0, rst_n = 1'b0, pin_a = 1'b0, pin_b = 1'b0, pin_c = 1'b0, reg_write, reg_read, reg_hit, al;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, sh [6], unm [3] = '{8'h1C, 8'h23, 8'hFF};
    logic       diff_a_active, diff_b_active, single_a_active, single_b_active, single_c_active, single_a_saving;
    logic       single_b_saving, single_c_saving, power_down_n, pin_reset, fourth_divider_source, single_b_source;
    logic       single_c_source, single_c_slow_freerun, loop_order_select, loop_channel_two_enable, diff_a_source;
    logic       loop_third_pole_enable, diff_hiz_at_powerdown, diff_a_bleg_polarity, diff_b_bleg_polarity;
    logic       diff_a_cmos_slew, diff_a_bleg_enable, watchdog_alarm;
    logic [1:0] dynamic_freq_control, diff_a_type;
    logic [2:0] single_slew;
    logic [5:0] supply_levels;
    int         num_errors = 0, n_checks = 0, seed = 20155, idx;
    always #5 clk = ~clk;
    reg_host_model host (.clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
    clock_output_control_regs #(.WD_PERIOD0(8), .WD_PERIOD1(16), .WD_PERIOD2(32), .WD_PERIOD3(64)) uut (
        .clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_hit, .pin_a, .pin_b, .pin_c,
        .diff_a_active, .diff_b_active, .single_a_active, .single_b_active, .single_c_active, .single_a_saving,
        .single_b_saving, .single_c_saving, .power_down_n, .pin_reset, .dynamic_freq_control, .fourth_divider_source,
        .single_slew, .supply_levels, .single_b_source, .single_c_source, .single_c_slow_freerun, .loop_order_select,
        .loop_channel_two_enable, .loop_third_pole_enable, .diff_hiz_at_powerdown, .diff_a_bleg_polarity,
        .diff_b_bleg_polarity, .diff_a_source, .diff_a_type, .diff_a_cmos_slew, .diff_a_bleg_enable, .watchdog_alarm);
    function automatic logic [24:0] exp_fields();
        return {sh[0][3], sh[4][3], sh[2][4], sh[0][2], sh[4][5:4], sh[2][6:5], sh[0][1:0], sh[2][7], sh[2][3:1],
                sh[4][7:6], sh[4][2:0], sh[5][7], sh[5][5:4], sh[5][1:0], al};
    endfunction
    function automatic logic [11:0] exp_pins();
        logic [1:0] fa, fb, fc;
        fa = sh[1][6:5];
        fb = sh[3][6:5];
        fc = sh[1][3:2];
        return {sh[0][5] & (!sh[0][7] | fb != 2'h1 | pin_b), sh[0][4] & (!sh[0][6] | fb != 2'h1 | pin_b),
                sh[1][7] & (fa != 2'h0 | pin_a), sh[3][7] & (fb != 2'h0 | pin_b), sh[1][4] & (fc != 2'h0 | pin_c),
                fa == 2'h2 & pin_a, fb == 2'h2 & pin_b, fc == 2'h2 & pin_c, !(fa == 2'h1 & !pin_a), fb == 2'h3 & pin_b,
                sh[3][4] ? {fc == 2'h3 ? pin_c : sh[1][1], fa == 2'h3 ? pin_a : sh[1][0]} : 2'h0};
    endfunction
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_outs(input logic [24:0] got, input logic [24:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t outputs got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pins();
        chk_outs({13'h0000, diff_a_active, diff_b_active, single_a_active, single_b_active, single_c_active,
                  single_a_saving, single_b_saving, single_c_saving, power_down_n, pin_reset, dynamic_freq_control},
                 {13'h0000, exp_pins()});
    endtask
    task automatic wreg(input int i, input logic [7:0] d);
        host.wr(8'h1D + 8'(i), d);
        sh[i] = d;
        if (i == 5) sh[i] = (d & 8'hB3) | 8'h04;
        if (i == 3) sh[i] = {d[7:1], al};
    endtask
    task automatic check_all();
        for (int i = 0; i < 6; i++) begin
            host.rd(8'h1D + 8'(i), v);
            chk_byte(v, sh[i]);
            chk_byte({7'h00, reg_hit}, 8'h01);
        end
        chk_outs({fourth_divider_source, single_slew, supply_levels, single_b_source, loop_order_select,
                  loop_channel_two_enable, loop_third_pole_enable, single_c_slow_freerun, single_c_source,
                  diff_hiz_at_powerdown, diff_a_bleg_polarity, diff_b_bleg_polarity, diff_a_source, diff_a_type,
                  diff_a_cmos_slew, diff_a_bleg_enable, watchdog_alarm}, exp_fields());
        chk_pins();
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        sh = '{8'h30, 8'h90, 8'h84, 8'h80, 8'h00, 8'hB4};
        al = 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #500000;
        num_errors++;
        test_done();
    end
    initial begin
        do_reset();
        check_all();
        for (int i = 0; i < 6; i++) begin
            wreg(i, i == 3 ? 8'hF7 : 8'hFF);
            check_all();
            wreg(i, 8'h00);
            check_all();
        end
        foreach (unm[k]) begin
            host.wr(unm[k], 8'hA5);
            host.rd(unm[k], v);
            chk_byte(v, 8'h00);
            chk_byte({7'h00, reg_hit}, 8'h00);
        end
        check_all();
        $display("test extremes done");
        for (int f = 0; f < 4; f++) begin
            wreg(0, 8'hF0);
            wreg(1, {1'b1, 2'(f), 1'b1, 2'(f), 2'h2});
            wreg(3, {1'b1, 2'(f), 5'h10});
            for (int p = 0; p < 8; p++) begin
                {pin_a, pin_b, pin_c} = 3'(p);
                @(negedge clk);
                chk_pins();
            end
        end
        $display("test pin functions done");
        repeat (120) begin
            idx = $unsigned($random(seed)) % 6;
            v = 8'($random(seed));
            v[3] = v[3] & (idx != 3);
            wreg(idx, v);
            {pin_a, pin_b, pin_c} = 3'($random(seed));
            check_all();
        end
        $display("test random done");
        for (int c = 0; c < 4; c++) begin
            do_reset();
            check_all();
            wreg(3, {5'h01, 2'(c), 1'b0});
            repeat ((8 << c) - 3) @(negedge clk);
            chk_byte({7'h00, watchdog_alarm}, 8'h00);
            repeat (9) @(negedge clk);
            al = 1'b1;
            chk_byte({7'h00, watchdog_alarm}, 8'h01);
            wreg(3, 8'h00);
            check_all();
        end
        $display("test watchdog done");
        test_done();
    end
endmodule
